// [inc/fpcls_pkg.sv]
// shared formats, constants and carriers for the fp operand classifier
package fpcls_pkg;
  // field layout of both formats
  localparam int FPCLS_SP_EXP_W = 8;
  localparam int FPCLS_DP_EXP_W = 11;
  localparam int FPCLS_SP_FRAC_W = 23;
  localparam int FPCLS_DP_FRAC_W = 52;
  localparam int FPCLS_SP_SIGN = 31;
  localparam int FPCLS_DP_SIGN = 63;
  localparam int FPCLS_SP_EXP_LO = 23;
  localparam int FPCLS_DP_EXP_LO = 52;
  localparam int FPCLS_FRAC_PAD = FPCLS_DP_FRAC_W - FPCLS_SP_FRAC_W;
  localparam int FPCLS_SIG_W = FPCLS_DP_FRAC_W + 1;
  localparam int FPCLS_EXPU_W = 12;
  // reserved exponent codes
  localparam logic [7:0] FPCLS_SP_EXP_MAX = 8'hFF;
  localparam logic [10:0] FPCLS_DP_EXP_MAX = 11'h7FF;
  // biases and minimum exponents, two's complement at FPCLS_EXPU_W
  localparam logic [11:0] FPCLS_SP_BIAS = 12'h07F;
  localparam logic [11:0] FPCLS_DP_BIAS = 12'h3FF;
  localparam logic [11:0] FPCLS_SP_EMIN = 12'hF82;
  localparam logic [11:0] FPCLS_DP_EMIN = 12'hC02;
  // default quiet nan patterns
  localparam logic [63:0] FPCLS_DP_QNAN = 64'h7FF8000000000000;
  localparam logic [63:0] FPCLS_SP_QNAN = 64'h000000007FC00000;
  localparam logic [63:0] FPCLS_SP_QBIT = 64'h0000000000400000;
  localparam logic [63:0] FPCLS_DP_QBIT = 64'h0008000000000000;

  // operation kinds issued by the pipeline
  typedef enum logic [3:0] {
    FPCLS_OP_ADD = 4'h0,
    FPCLS_OP_SUB = 4'h1,
    FPCLS_OP_MUL = 4'h2,
    FPCLS_OP_DIV = 4'h3,
    FPCLS_OP_MADD = 4'h4,
    FPCLS_OP_MSUB = 4'h5,
    FPCLS_OP_CMPU = 4'h6,
    FPCLS_OP_CMPO = 4'h7,
    FPCLS_OP_RSP = 4'h8,
    FPCLS_OP_CVTI = 4'h9
  } fpcls_op_t;

  // one-hot class plus sign
  typedef struct packed {
    logic sign;
    logic norm;
    logic denorm;
    logic zero;
    logic inf;
    logic snan;
    logic qnan;
  } fpcls_class_t;

  // class with significand and unbiased exponent
  typedef struct packed {
    fpcls_class_t cls;
    logic [FPCLS_EXPU_W-1:0] exp_unb;
    logic [FPCLS_SIG_W-1:0] sig;
  } fpcls_info_t;

  typedef struct packed {
    logic lt;
    logic gt;
    logic eq;
    logic un;
  } fpcls_cmp_t;

  // registered result of one issued operation
  typedef struct packed {
    logic valid;
    logic nan;
    logic [63:0] value;
    logic invalid;
    logic snan_exc;
    logic trap;
    fpcls_cmp_t cmp;
  } fpcls_state_t;
endpackage : fpcls_pkg

// [rtl/fpcls_classify.sv]
`timescale 1ns/100ps
// splits one operand into fields and classifies it
module fpcls_classify
  import fpcls_pkg::*;
(
  input wire logic dbl, // 1: double, 0: single in low word
  input wire logic [63:0] op, // raw operand
  output fpcls_info_t info // class, exponent, significand
);
  logic sign;
  logic [10:0] exp_f;
  logic [51:0] frac;
  logic exp_zero;
  logic exp_max;
  logic frac_zero;
  logic [11:0] exp_ext;

  // field split per precision
  always_comb begin
    if (dbl) begin
      sign = op[FPCLS_DP_SIGN];
      exp_f = op[FPCLS_DP_EXP_LO +: FPCLS_DP_EXP_W];
      frac = op[FPCLS_DP_FRAC_W-1:0];
      exp_zero = (exp_f == '0);
      exp_max = (exp_f == FPCLS_DP_EXP_MAX);
      exp_ext = {1'b0, exp_f} - FPCLS_DP_BIAS;
    end else begin
      sign = op[FPCLS_SP_SIGN];
      exp_f = {3'h0, op[FPCLS_SP_EXP_LO +: FPCLS_SP_EXP_W]};
      frac = {op[FPCLS_SP_FRAC_W-1:0], {FPCLS_FRAC_PAD{1'b0}}};
      exp_zero = (exp_f[7:0] == '0);
      exp_max = (exp_f[7:0] == FPCLS_SP_EXP_MAX);
      exp_ext = {4'h0, exp_f[7:0]} - FPCLS_SP_BIAS;
    end
    frac_zero = (frac == '0);
  end

  // exactly one class bit is set for any pattern
  always_comb begin
    info.cls.sign = sign & ~exp_max | sign & frac_zero;
    info.cls.norm = ~exp_zero & ~exp_max;
    info.cls.zero = exp_zero & frac_zero;
    info.cls.denorm = exp_zero & ~frac_zero;
    info.cls.inf = exp_max & frac_zero;
    info.cls.snan = exp_max & ~frac_zero & ~frac[FPCLS_DP_FRAC_W-1];
    info.cls.qnan = exp_max & ~frac_zero & frac[FPCLS_DP_FRAC_W-1];
    info.sig = {info.cls.norm, frac};
    if (exp_zero) begin
      info.exp_unb = dbl ? FPCLS_DP_EMIN : FPCLS_SP_EMIN;
    end else begin
      info.exp_unb = exp_ext;
    end
  end
endmodule : fpcls_classify

// [rtl/fpcls_nan_pick.sv]
`timescale 1ns/100ps
// priority choice of the nan result, always stored quiet
module fpcls_nan_pick
  import fpcls_pkg::*;
(
  input wire logic dbl, // precision of the result
  input wire logic [63:0] src_a, // first source
  input wire logic [63:0] src_b, // second source
  input wire logic [63:0] src_c, // third source
  input wire logic [2:0] is_nan, // nan and used, per source
  input wire logic gen_qnan, // disabled invalid op
  output logic hit, // a nan result exists
  output logic [63:0] value // chosen quiet nan
);
  logic [63:0] pick;

  // first, second, third source, then the default
  always_comb begin
    hit = 1'b1;
    if (is_nan[0]) begin
      pick = src_a;
    end else if (is_nan[1]) begin
      pick = src_b;
    end else if (is_nan[2]) begin
      pick = src_c;
    end else begin
      pick = dbl ? FPCLS_DP_QNAN : FPCLS_SP_QNAN;
      hit = gen_qnan;
    end
    // quiet bit forced so signaling sources leave quiet
    value = pick | (dbl ? FPCLS_DP_QBIT : FPCLS_SP_QBIT);
    if (!dbl) begin
      value[63:32] = '0;
    end
  end
endmodule : fpcls_nan_pick

// [rtl/fpcls_top.sv]
// Overview of operation
// - exponent strictly inside range: normalized, unit one
// - zero exponent and fraction: signed zero
// - compare treats +0 and -0 as equal
// - zero exponent, nonzero fraction: denormal, minimum exponent
// - max exponent, zero fraction: signed infinity
// - minus infinity lowest, plus infinity highest
// - infinity arithmetic exact except invalid cases
// - max exponent, nonzero fraction: nan, unsigned
// - fraction msb zero signaling, one quiet
// - signaling nan operand raises exception
// - invalid arithmetic with enable clear gives quiet nan
// - quiet nan propagates except compare, round, convert
// - quiet nan raises only ordered compare, convert
// - nan result: first, second, third, then default
// - stored nan always has quiet bit set
// - default nan: sign 0, ones, msb one
// - sign, 8/23 or 11/52 exponent and fraction
`timescale 1ns/100ps
module fpcls_top
  import fpcls_pkg::*;
(
  input wire logic mclk, // 40 MHz pipeline clock
  input wire logic reset, // async, active high
  input wire logic op_valid, // operation issued this cycle
  input wire fpcls_op_t op_kind, // kind of operation
  input wire logic dbl_sel, // 1: double, 0: single
  input wire logic [63:0] first_source_operand, // source a
  input wire logic [63:0] second_source_operand, // source b
  input wire logic [63:0] third_source_operand, // source c
  input wire logic [2:0] src_used, // bit n: source n+1 used
  input wire logic invalid_op_enable, // trap invalid instead of qnan
  output fpcls_info_t first_info, // class of source a
  output fpcls_info_t second_info, // class of source b
  output fpcls_info_t third_info, // class of source c
  output fpcls_cmp_t cmp_now, // a versus b, this cycle
  output logic res_valid, // result fields below are fresh
  output logic res_nan, // result is a nan
  output logic [63:0] res_value, // nan result value
  output logic invalid_flag, // invalid operation seen
  output logic snan_flag, // signaling nan operand seen
  output logic trap_req, // invalid with enable set
  output fpcls_cmp_t cmp_res // registered compare
);
  fpcls_state_t st_q;
  fpcls_state_t st_d;
  fpcls_class_t ca;
  fpcls_class_t cb;
  fpcls_class_t cc;
  logic [2:0] nan_used;
  logic snan_any;
  logic qnan_any;
  logic prop_op;
  logic inf_inv;
  logic qnan_inv;
  logic invalid;
  logic gen_qnan;
  logic nan_hit;
  logic [63:0] nan_value;
  logic prod_inf;
  logic prod_bad;
  logic prod_sign;
  logic [63:0] key_a;
  logic [63:0] key_b;
  logic trap_now;
  logic unordered;

  // ordering key: unsigned compare of keys matches numeric order
  function automatic logic [63:0] fpcls_key(
    input logic [63:0] op,
    input logic dbl,
    input logic is_zero
  );
    logic [62:0] mag;
    logic sgn;
    if (dbl) begin
      mag = op[FPCLS_DP_SIGN-1:0];
      sgn = op[FPCLS_DP_SIGN];
    end else begin
      // single lives in the low word; the upper word is ignored
      mag = {{(FPCLS_DP_SIGN - FPCLS_SP_SIGN){1'b0}}, op[FPCLS_SP_SIGN-1:0]};
      sgn = op[FPCLS_SP_SIGN];
    end
    if (is_zero) begin
      fpcls_key = {1'b1, 63'h0};
    end else if (sgn) begin
      fpcls_key = {1'b0, ~mag};
    end else begin
      fpcls_key = {1'b1, mag};
    end
  endfunction : fpcls_key

  // nan test for one class, either flavour
  function automatic logic fpcls_is_nan(input fpcls_class_t c);
    fpcls_is_nan = c.snan | c.qnan;
  endfunction : fpcls_is_nan

  // two infinities that cancel: add of unlike signs, subtract of like signs
  function automatic logic fpcls_inf_clash(
    input logic x_inf,
    input logic x_sgn,
    input logic y_inf,
    input logic y_sgn,
    input logic do_sub
  );
    logic differ;
    differ = x_sgn ^ y_sgn;
    // subtracting flips the effective sign of the second term
    fpcls_inf_clash = x_inf & y_inf & (differ ^ do_sub);
  endfunction : fpcls_inf_clash

  // zero times infinity has no value
  function automatic logic fpcls_zero_inf(input fpcls_class_t x, input fpcls_class_t y);
    fpcls_zero_inf = (x.inf & y.zero) | (x.zero & y.inf);
  endfunction : fpcls_zero_inf

  // three identical classifiers, one per source
  fpcls_classify u_cls_a (
    .dbl(dbl_sel),
    .op(first_source_operand),
    .info(first_info)
  );
  fpcls_classify u_cls_b (
    .dbl(dbl_sel),
    .op(second_source_operand),
    .info(second_info)
  );
  fpcls_classify u_cls_c (
    .dbl(dbl_sel),
    .op(third_source_operand),
    .info(third_info)
  );

  assign ca = first_info.cls;
  assign cb = second_info.cls;
  assign cc = third_info.cls;

  // unused sources never count toward nan choice
  assign nan_used[0] = src_used[0] & fpcls_is_nan(ca);
  assign nan_used[1] = src_used[1] & fpcls_is_nan(cb);
  assign nan_used[2] = src_used[2] & fpcls_is_nan(cc);
  assign snan_any = |(src_used & {cc.snan, cb.snan, ca.snan});
  assign qnan_any = |(src_used & {cc.qnan, cb.qnan, ca.qnan});

  // a against b; keys only valid when neither is a nan
  assign key_a = fpcls_key(first_source_operand, dbl_sel, ca.zero);
  assign key_b = fpcls_key(second_source_operand, dbl_sel, cb.zero);
  // a nan on either side leaves the pair unordered
  assign unordered = fpcls_is_nan(ca) | fpcls_is_nan(cb);
  always_comb begin
    cmp_now.un = unordered;
    cmp_now.eq = ~cmp_now.un & (key_a == key_b);
    cmp_now.lt = ~cmp_now.un & (key_a < key_b);
    cmp_now.gt = ~cmp_now.un & (key_a > key_b);
  end

  // product a*c for multiply and fused forms
  assign prod_bad = fpcls_zero_inf(ca, cc);
  assign prod_inf = (ca.inf | cc.inf) & ~prod_bad;
  assign prod_sign = ca.sign ^ cc.sign;

  // infinity and zero-over-zero cases that are invalid; all others stay exact
  always_comb begin
    inf_inv = 1'b0;
    case (op_kind)
      FPCLS_OP_ADD: begin
        inf_inv = fpcls_inf_clash(ca.inf, ca.sign, cb.inf, cb.sign, 1'b0);
      end
      FPCLS_OP_SUB: begin
        inf_inv = fpcls_inf_clash(ca.inf, ca.sign, cb.inf, cb.sign, 1'b1);
      end
      FPCLS_OP_MUL: begin
        inf_inv = prod_bad;
      end
      FPCLS_OP_DIV: begin
        inf_inv = (ca.inf & cb.inf) | (ca.zero & cb.zero);
      end
      FPCLS_OP_MADD: begin
        inf_inv = prod_bad | fpcls_inf_clash(prod_inf, prod_sign, cb.inf, cb.sign, 1'b0);
      end
      FPCLS_OP_MSUB: begin
        inf_inv = prod_bad | fpcls_inf_clash(prod_inf, prod_sign, cb.inf, cb.sign, 1'b1);
      end
      FPCLS_OP_CVTI: begin
        // an infinite source has no integer image
        inf_inv = cb.inf;
      end
      default: inf_inv = 1'b0;
    endcase
  end

  // quiet nans only trouble ordered compares and conversions
  always_comb begin
    case (op_kind)
      FPCLS_OP_CMPO: qnan_inv = qnan_any;
      FPCLS_OP_CVTI: qnan_inv = qnan_any;
      default: qnan_inv = 1'b0;
    endcase
  end

  // only arithmetic kinds carry a nan through to the result
  always_comb begin
    case (op_kind)
      FPCLS_OP_CMPU: prop_op = 1'b0;
      FPCLS_OP_CMPO: prop_op = 1'b0;
      FPCLS_OP_RSP: prop_op = 1'b0;
      FPCLS_OP_CVTI: prop_op = 1'b0;
      default: prop_op = 1'b1;
    endcase
  end

  assign invalid = snan_any | inf_inv | qnan_inv;
  // enabled invalid traps instead of writing a result
  assign trap_now = invalid & invalid_op_enable;
  // a trap suppresses the result, so no default nan then
  assign gen_qnan = invalid & ~invalid_op_enable & prop_op;

  fpcls_nan_pick u_pick (
    .dbl(dbl_sel),
    .src_a(first_source_operand),
    .src_b(second_source_operand),
    .src_c(third_source_operand),
    .is_nan(nan_used),
    .gen_qnan(gen_qnan),
    .hit(nan_hit),
    .value(nan_value)
  );

  // next state: capture one issued operation per cycle
  always_comb begin
    st_d = st_q;
    st_d.valid = op_valid;
    if (op_valid) begin
      st_d.invalid = invalid;
      st_d.snan_exc = snan_any;
      st_d.trap = trap_now;
      st_d.nan = nan_hit & prop_op & ~trap_now;
      st_d.value = st_d.nan ? nan_value : '0;
      st_d.cmp = cmp_now;
    end else begin
      // flags are one-cycle pulses tied to valid
      st_d.invalid = 1'b0;
      st_d.snan_exc = 1'b0;
      st_d.trap = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // all registered outputs come straight from the state
  assign res_valid = st_q.valid;
  assign res_nan = st_q.nan;
  assign res_value = st_q.value;
  assign invalid_flag = st_q.invalid;
  assign snan_flag = st_q.snan_exc;
  assign trap_req = st_q.trap;
  assign cmp_res = st_q.cmp;
endmodule : fpcls_top

// [tb/fpcls_pipe_model.sv]
`timescale 1ns/100ps
// pipeline side: issues one operation, drives it until the taking edge
module fpcls_pipe_model
  import fpcls_pkg::*;
(
  input wire logic mclk, // pipeline clock
  output logic op_valid, // issue strobe
  output fpcls_op_t op_kind, // operation kind
  output logic dbl_sel, // precision
  output logic [63:0] src_a, // source a
  output logic [63:0] src_b, // source b
  output logic [63:0] src_c, // source c
  output logic [2:0] src_used, // used sources
  output logic ve // invalid enable
);
  // idle values at time zero
  initial begin
    op_valid = 1'b0;
    op_kind = FPCLS_OP_ADD;
    dbl_sel = 1'b0;
    src_a = 64'h0;
    src_b = 64'h0;
    src_c = 64'h0;
    src_used = 3'h0;
    ve = 1'b0;
  end

  // launch just after an edge; #1 lets the classifier settle
  task automatic put(input fpcls_op_t k, input logic d, input logic [63:0] a, b, c,
    input logic [2:0] u, input logic v);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_kind <= k;
    dbl_sel <= d;
    src_a <= a;
    src_b <= b;
    src_c <= c;
    src_used <= u;
    ve <= v;
    #1;
  endtask : put

  // the edge takes the operation; operands stay, strobe drops
  task automatic take();
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
  endtask : take
endmodule : fpcls_pipe_model

// [tb/fpcls_top_sva.sv]
`timescale 1ns/100ps
// timing and class relations at the classifier ports
module fpcls_top_sva
  import fpcls_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // async reset
  input wire logic op_valid, // issue
  input wire logic dbl_sel, // precision
  input wire logic [2:0] src_used, // used sources
  input wire fpcls_info_t first_info, // class a
  input wire fpcls_info_t second_info, // class b
  input wire fpcls_cmp_t cmp_now, // compare now
  input wire logic res_valid, // result strobe
  input wire logic res_nan, // nan result
  input wire logic [63:0] res_value, // nan value
  input wire logic invalid_flag, // invalid seen
  input wire logic snan_flag, // snan seen
  input wire logic trap_req // trap
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // one answer per issue, none when idle
  res_pulse_a: assert property (op_valid |=> res_valid) else $error("no result after issue");
  idle_quiet_a: assert property (!op_valid |=> !(res_valid || invalid_flag || snan_flag || trap_req))
    else $error("pulse without issue");
  one_class_a: assert property ($onehot({first_info.cls.norm, first_info.cls.denorm, first_info.cls.zero,
    first_info.cls.inf, first_info.cls.snan, first_info.cls.qnan})) else $error("class not one-hot");
  // compare relations follow the classes of the same cycle
  zero_equal_a: assert property (first_info.cls.zero && second_info.cls.zero |-> cmp_now == 4'h2)
    else $error("signed zeros unequal");
  nan_unordered_a: assert property (first_info.cls.snan || first_info.cls.qnan |-> cmp_now.un && !cmp_now.eq
    && !first_info.cls.sign) else $error("nan ordered or signed");
  inf_order_a: assert property (first_info.cls.inf && first_info.cls.sign && !(second_info.cls.inf ||
    second_info.cls.snan || second_info.cls.qnan) |-> cmp_now.lt) else $error("minus inf not lowest");
  // a stored nan is quiet in the issuing precision
  quiet_store_a: assert property (res_valid && res_nan |-> ($past(dbl_sel) ? res_value[51] : res_value[22]))
    else $error("stored nan not quiet");
  snan_raise_a: assert property (op_valid && src_used[0] && first_info.cls.snan |=> snan_flag && invalid_flag)
    else $error("snan not flagged");
  trap_excl_a: assert property (trap_req |-> invalid_flag && !res_nan) else $error("trap with nan result");
  // the stored result stands until the next issue
  result_hold_a: assert property (!op_valid |=> $stable(res_nan) && $stable(res_value))
    else $error("result changed while idle");
endmodule : fpcls_top_sva

bind fpcls_top fpcls_top_sva fpcls_top_sva_i (.mclk, .reset, .op_valid, .dbl_sel, .src_used, .first_info,
  .second_info, .cmp_now, .res_valid, .res_nan, .res_value, .invalid_flag, .snan_flag, .trap_req);

// [tb/tb_fpcls_top.sv]
`timescale 1ns/100ps
// self-checking bench for the classifier and nan selection
module tb_fpcls_top
  import fpcls_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic op_valid, dbl_sel, ve;
  fpcls_op_t op_kind;
  logic [63:0] sa, sb, sc, res_value;
  logic [2:0] src_used;
  fpcls_info_t i_a, i_b, i_c;
  fpcls_cmp_t cmp_now, cmp_res;
  logic res_valid, res_nan, invalid_flag, snan_flag, trap_req;
  int n_errors = 0;
  int samples_checked = 0;
  // class table: precision, operand, {sign,norm,denorm,zero,inf,snan,qnan}, unbiased exponent
  logic cd [10] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [63:0] cv [10] = '{64'h3FF0000000000000, 64'h1, 64'h80000000, 64'h7F800000, 64'hFF800001,
    64'hFFF8000000000001, 64'h7F7FFFFF, 64'h00800000, 64'hFFEFFFFFFFFFFFFF, 64'hFFFFFFFF00000000};
  logic [6:0] cc [10] = '{7'h20, 7'h10, 7'h48, 7'h04, 7'h02, 7'h01, 7'h20, 7'h20, 7'h60, 7'h08};
  logic [11:0] ce [10] = '{12'h000, 12'hC02, 12'hF82, 12'h0, 12'h0, 12'h0, 12'h07F, 12'hF82, 12'h3FF, 12'hF82};

  always #12.5 mclk = ~mclk;

  fpcls_pipe_model fpcls_pipe_model_i (.mclk(mclk), .op_valid(op_valid), .op_kind(op_kind), .dbl_sel(dbl_sel),
    .src_a(sa), .src_b(sb), .src_c(sc), .src_used(src_used), .ve(ve));
  fpcls_top fpcls_top_i (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op_kind(op_kind), .dbl_sel(dbl_sel),
    .first_source_operand(sa), .second_source_operand(sb), .third_source_operand(sc), .src_used(src_used),
    .invalid_op_enable(ve), .first_info(i_a), .second_info(i_b), .third_info(i_c), .cmp_now(cmp_now),
    .res_valid(res_valid), .res_nan(res_nan), .res_value(res_value), .invalid_flag(invalid_flag),
    .snan_flag(snan_flag), .trap_req(trap_req), .cmp_res(cmp_res));

  task automatic chk(input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one issued operation; ef is {valid,nan,invalid,snan,trap}
  task automatic op(input fpcls_op_t k, input logic d, input logic [63:0] a, b, c, input logic [2:0] u,
    input logic v, input logic [4:0] ef, input logic [63:0] ev);
    fpcls_pipe_model_i.put(k, d, a, b, c, u, v);
    fpcls_pipe_model_i.take();
    chk({59'h0, res_valid, res_nan, invalid_flag, snan_flag, trap_req}, {59'h0, ef});
    chk(res_value, ev);
  endtask : op

  // every class, both precisions; class on sources a and c, exponent on b
  task automatic t_classify();
    logic [52:0] es;
    for (int i = 0; i < 10; i++) begin
      // implied bit only for normalized; single fraction left-aligned
      es = cd[i] ? {cc[i][5], cv[i][51:0]} : {cc[i][5], cv[i][22:0], 29'h0};
      fpcls_pipe_model_i.put(FPCLS_OP_CMPU, cd[i], cv[i], cv[i], cv[i], 3'h0, 1'b0);
      chk({11'h0, i_a.sig}, {11'h0, es});
      chk({57'h0, i_a.cls}, {57'h0, cc[i]});
      chk({57'h0, i_c.cls}, {57'h0, cc[i]});
      if (cc[i][3:0] == 4'h0 || cc[i][3] == 1'b1) chk({52'h0, i_b.exp_unb}, {52'h0, ce[i]});
      fpcls_pipe_model_i.take();
    end
  endtask : t_classify

  // combinational and registered compare agree
  task automatic t_cmp(input logic [63:0] a, b, input logic [3:0] e);
    fpcls_pipe_model_i.put(FPCLS_OP_CMPU, 1'b1, a, b, 64'h0, 3'h3, 1'b0);
    chk({60'h0, cmp_now}, {60'h0, e});
    fpcls_pipe_model_i.take();
    chk({60'h0, cmp_res}, {60'h0, e});
  endtask : t_cmp

  // nan priority, default nan, quieting and exception cases
  task automatic t_nan();
    op(FPCLS_OP_ADD, 1, 64'h3FF0000000000000, 64'h7FF8000000000002, 64'h0, 3'h3, 0, 5'h18,
      64'h7FF8000000000002);
    op(FPCLS_OP_MUL, 1, 64'h3FF0000000000000, 64'h7FF8000000000002, 64'h7FF8000000000003, 3'h5, 0, 5'h18,
      64'h7FF8000000000003);
    op(FPCLS_OP_MADD, 1, 64'h7FF0000000000004, 64'h7FF8000000000002, 64'h7FF8000000000003, 3'h7, 0, 5'h1E,
      64'h7FF8000000000004);
    op(FPCLS_OP_ADD, 1, 64'h7FF0000000000000, 64'hFFF0000000000000, 64'h0, 3'h3, 0, 5'h1C,
      64'h7FF8000000000000);
    op(FPCLS_OP_ADD, 1, 64'h7FF0000000000000, 64'hFFF0000000000000, 64'h0, 3'h3, 1, 5'h15, 64'h0);
    op(FPCLS_OP_SUB, 0, 64'h7F800000, 64'h7F800000, 64'h0, 3'h3, 0, 5'h1C, 64'h7FC00000);
    op(FPCLS_OP_ADD, 1, 64'h7FF0000000000000, 64'h3FF0000000000000, 64'h0, 3'h3, 0, 5'h10, 64'h0);
    op(FPCLS_OP_DIV, 1, 64'h0, 64'h8000000000000000, 64'h0, 3'h3, 0, 5'h1C, 64'h7FF8000000000000);
    op(FPCLS_OP_CMPO, 1, 64'h7FF8000000000002, 64'h0, 64'h0, 3'h3, 0, 5'h14, 64'h0);
    op(FPCLS_OP_CMPU, 1, 64'h7FF8000000000002, 64'h0, 64'h0, 3'h3, 0, 5'h10, 64'h0);
    op(FPCLS_OP_RSP, 1, 64'h0, 64'h7FF8000000000002, 64'h0, 3'h2, 0, 5'h10, 64'h0);
    op(FPCLS_OP_CVTI, 1, 64'h0, 64'h7FF8000000000002, 64'h0, 3'h2, 0, 5'h14, 64'h0);
    op(FPCLS_OP_CVTI, 1'b1, 64'h0, 64'hFFF0000000000000, 64'h0, 3'h2, 1'b0, 5'h14, 64'h0);
    op(FPCLS_OP_MUL, 1'b1, 64'h7FF0000000000000, 64'h0, 64'h8000000000000000, 3'h5, 1'b0, 5'h1C,
      64'h7FF8000000000000);
    op(FPCLS_OP_MSUB, 1'b1, 64'h7FF0000000000000, 64'h7FF0000000000000, 64'h3FF0000000000000, 3'h7, 1'b0,
      5'h1C, 64'h7FF8000000000000);
    op(FPCLS_OP_MADD, 1'b1, 64'h7FF0000000000000, 64'h7FF0000000000000, 64'h3FF0000000000000, 3'h7, 1'b0,
      5'h10, 64'h0);
  endtask : t_nan

  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_classify();
    t_cmp(64'h0, 64'h8000000000000000, 4'h2);
    t_cmp(64'hFFF0000000000000, 64'h7FEFFFFFFFFFFFFF, 4'h8);
    t_cmp(64'h7FF0000000000000, 64'hFFEFFFFFFFFFFFFF, 4'h4);
    t_cmp(64'h7FF8000000000001, 64'h3FF0000000000000, 4'h1);
    t_nan();
    stop_test();
  end

  // watchdog: the run needs well under 100 cycles of operations
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule : tb_fpcls_top
